// ---- bench/msp_props.sv ----
// assertions on the mode select pin mux ports
`timescale 1ns/100ps
module msp_props #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int ECLK_DIV     = 4
) (
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire logic               mode_strap_a_pin_out,
    input wire logic               mode_strap_a_pin_oe,
    input wire logic               opcode_fetch,
    input wire logic               strobe_drive_high_bit,
    input wire msp_pkg::msp_bus_t  bus,
    input wire msp_pkg::msp_mode_t mode,
    input wire logic               expanded_bus,
    input wire logic               eclk,
    input wire logic [7:0]         gpio_b_out,
    input wire logic [7:0]         gpio_g_out,
    input wire logic [7:0]         port_b_out,
    input wire logic [7:0]         port_f_out,
    input wire logic [7:0]         port_g_out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // strobe pulled low; a new e cycle begins just after e falls
    sequence s_low; mode_strap_a_pin_oe && !mode_strap_a_pin_out; endsequence
    sequence s_start; !eclk && $past(eclk); endsequence
    // mode loads one edge after release, so skip two edges
    property p_hold;
        !$past(rst, 2) && !$past(rst) |-> $stable(mode);
    endproperty
    a_hold: assert property (p_hold) else $error("mode moved");
    property p_nostrb; !mode[0] |-> !mode_strap_a_pin_oe; endproperty
    a_nostrb: assert property (p_nostrb) else $error("strobe on");
    property p_fetch;
        s_start ##0 (mode[0] && opcode_fetch) |-> ##1 s_low [*4];
    endproperty
    a_fetch: assert property (p_fetch) else $error("no strobe");
    property p_kick;
        s_start ##0 (!opcode_fetch && strobe_drive_high_bit) ##0 s_low |->
            ##1 (mode_strap_a_pin_oe && mode_strap_a_pin_out) ##1
            !mode_strap_a_pin_oe;
    endproperty
    a_kick: assert property (p_kick) else $error("no high kick");
    property p_hi;
        mode_strap_a_pin_oe && mode_strap_a_pin_out |->
            $past(strobe_drive_high_bit);
    endproperty
    a_hi: assert property (p_hi) else $error("driven high");
    property p_eclk; $rose(eclk) |=> eclk ##1 !eclk [*2] ##1 eclk; endproperty
    a_eclk: assert property (p_eclk) else $error("bad e clock");
    property p_bus;
        expanded_bus |=> {port_b_out, port_f_out} == $past(bus.addr) &&
            port_g_out[7] == $past(bus.rw);
    endproperty
    a_bus: assert property (p_bus) else $error("bad bus pins");
    property p_gpio;
        !mode[0] && !$past(rst) |=> port_b_out == $past(gpio_b_out) &&
            port_g_out == $past(gpio_g_out);
    endproperty
    a_gpio: assert property (p_gpio) else $error("bad gpio");
endmodule : msp_props

bind msp_pin_mux msp_props #(
    .FULL_VARIANT(FULL_VARIANT), .ECLK_DIV(ECLK_DIV)
) u_props (.*);

// ---- bench/msp_strap_model.sv ----
// board straps, fetch strobe wire and memory read data
`timescale 1ns/100ps
module msp_strap_model (
    input  wire logic [1:0] strap,
    input  wire logic       a_out,
    input  wire logic       a_oe,
    input  wire logic [7:0] c_out,
    input  wire logic [7:0] c_oe,
    input  wire logic [7:0] mem_rd,
    output logic            a_pin,
    output logic            b_pin,
    output logic [7:0]      c_pin
);
    // pull-up or ground on a when released, b tied
    assign a_pin = a_oe ? a_out : strap[0];
    assign b_pin = strap[1];
    // memory answers on lines the device does not drive
    assign c_pin = (c_oe & c_out) | (~c_oe & mem_rd);
endmodule : msp_strap_model

// ---- bench/msp_tb.sv ----
// self-checking bench for the mode select pin mux
`timescale 1ns/100ps
module testbench;
    logic               ref_clk, rst, fetch, hi_bit, a_out, a_oe, a_pin, e0;
    logic               b_pin, eclk, xa_en, cs_en;
    logic [1:0]         strap;
    logic [6:0]         xa_l;
    logic [3:0]         cs_l;
    logic [7:0]         g, mem_rd, c_pin, din, pb, pc, pce, pf, pg, ph;
    logic [7:0]         pbe, pfe, pge, phe, gx, hx;
    msp_pkg::msp_bus_t  bus;
    msp_pkg::msp_mode_t mode;
    int                 n_mismatch, n_tests, m, i;
    // enables follow strap b, so the mode gate is tried both ways
    msp_pin_mux uut (.ref_clk(ref_clk), .rst(rst), .mode_strap_a_pin_in(a_pin),
        .mode_strap_a_pin_out(a_out), .mode_strap_a_pin_oe(a_oe),
        .mode_strap_b_pin(b_pin), .opcode_fetch(fetch), .bus(bus),
        .strobe_drive_high_bit(hi_bit), .xa_enable(xa_en), .cs_enable(cs_en),
        .xa_lines(xa_l), .cs_lines(cs_l), .mode(mode), .expanded_bus(),
        .eclk(eclk), .bus_data_in(din), .gpio_b_out(g), .gpio_b_oe(~g),
        .gpio_c_out(g ^ 8'h0f), .gpio_c_oe(~g), .gpio_f_out(g ^ 8'hf0),
        .gpio_f_oe(g), .gpio_g_out(g ^ 8'h3c), .gpio_g_oe(g),
        .gpio_h_out(g ^ 8'h5a), .gpio_h_oe(~g), .port_c_in(c_pin),
        .port_b_out(pb), .port_b_oe(pbe), .port_c_out(pc), .port_c_oe(pce),
        .port_f_out(pf), .port_f_oe(pfe), .port_g_out(pg), .port_g_oe(pge),
        .port_h_out(ph), .port_h_oe(phe));
    msp_strap_model board (.strap(strap), .a_out(a_out), .a_oe(a_oe),
        .c_out(pc), .c_oe(pce), .mem_rd(mem_rd), .a_pin(a_pin),
        .b_pin(b_pin), .c_pin(c_pin));
    // 125 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // one e cycle: fetch is raised so that the next start edge samples it
    task automatic op(input logic f);
        repeat (3) @(posedge ref_clk);
        fetch <= f;
        @(posedge ref_clk);
        fetch <= 1'b0;
    endtask : op
    // every strap setting, then bus pins and the strobe in that mode
    initial begin
        rst = 1'b1;
        strap = 2'b11;
        {fetch, hi_bit, g, mem_rd, bus, xa_l, cs_l, xa_en, cs_en} = '0;
        {n_mismatch, n_tests} = '0;
        for (m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            rst   <= 1'b1;
            strap <= m[1:0];
            repeat (6) @(posedge ref_clk);
            rst <= 1'b0;
            repeat (4) @(posedge ref_clk);
            strap  <= ~m[1:0];
            g      <= 8'h96 ^ 8'(m);
            bus    <= {16'h9a5c ^ 16'(m), 8'h6b, 1'b0, m[0]};
            mem_rd <= 8'h3d ^ 8'(m);
            xa_l   <= 7'h55 ^ 7'(m);
            cs_l   <= 4'ha ^ 4'(m);
            xa_en  <= m[1];
            cs_en  <= m[1];
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            check(mode, m[1:0]);
            gx = g ^ 8'h3c;
            hx = g ^ 8'h5a;
            // test mode runs with the enables off, expanded with them on
            if (m[0]) begin
                check({pb, pf}, bus.addr);
                check(pg, {bus.rw, m[1] ? xa_l : gx[6:0]});
                check(ph, {m[1] ? cs_l : hx[7:4], hx[3:0]});
                check({pbe, pfe}, 16'hffff);
                check({pce, pc}, {8'h00, 8'h6b});
                check(pge, {1'b1, m[1] ? 7'h7f : g[6:0]});
                check(phe, {m[1] ? 4'hf : ~g[7:4], ~g[3:0]});
                check(din, mem_rd);
            end else begin
                check({pb, pf}, {g, g ^ 8'hf0});
                check({pg, ph}, {gx, hx});
                check({pbe, pfe}, {~g, g});
                check({pge, phe}, {g, ~g});
                check({pce, pc}, {~g, g ^ 8'h0f});
            end
            @(posedge ref_clk);
            strap  <= m[1:0];
            hi_bit <= m[1];
            // find the phase of e, bounded
            for (i = 0; i < 9; i++) begin
                e0 = eclk;
                @(negedge ref_clk);
                if (e0 && !eclk) break;
            end
            if (i == 9) begin
                n_mismatch++;
                report_and_stop();
            end
            @(posedge ref_clk);
            op(1'b1);
            op(1'b1);
            // no further fetch: the next start edge ends the strobe
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            check({a_oe, a_pin}, {m[0], 1'b0});
            @(negedge ref_clk);
            check({a_oe, a_pin}, {m[0] & m[1], m[0]});
            @(negedge ref_clk);
            check(a_oe, 1'b0);
            check(mode, m[1:0]);
        end
        report_and_stop();
    end
endmodule : testbench

// ---- verilog/msp_consts.svh ----
// timing counts and field positions for the mode select pin mux
`ifndef MSP_CONSTS_SVH
`define MSP_CONSTS_SVH
`define MSP_CLK_PERIOD_NS 8
`define MSP_ECLK_DIV 4
`define MSP_QTR_CYCLES 1
`define MSP_PORT_W 8
`define MSP_PORTD_W 6
`define MSP_PG_RW_BIT 7
`define MSP_PG_XA_W 7
`define MSP_PH_CS_LSB 4
`define MSP_PH_CS_W 4
`endif

// ---- verilog/msp_eclk.sv ----
// e clock divider giving quarter-cycle phase enables
`timescale 1ns/100ps
`include "msp_consts.svh"
module msp_eclk #(
    parameter int DIV = `MSP_ECLK_DIV
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    output logic      eclk,
    output logic      cyc_start,
    output logic      last_qtr
);
    logic [$clog2(DIV)-1:0] cnt;

    initial begin
        if (DIV < 4 || DIV % 2 != 0)
            $error("msp_eclk: DIV must be even and at least 4");
    end

    // free running phase count, one e cycle per DIV ref clocks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (cnt == $clog2(DIV)'(DIV - 1)) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // e low in address half, high in data half
    assign eclk      = (cnt >= $clog2(DIV)'(DIV / 2));
    assign cyc_start = (cnt == '0);
    assign last_qtr  = (cnt >= $clog2(DIV)'(DIV - DIV / 4));
endmodule : msp_eclk

// ---- verilog/msp_pin_mux.sv ----
// mode strap capture and port pin multiplexer
`timescale 1ns/100ps
`include "msp_consts.svh"
module msp_pin_mux #(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int ECLK_DIV     = `MSP_ECLK_DIV
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // strap pins, a is two-way after reset in test and expanded modes
    input  wire logic                    mode_strap_a_pin_in,
    output logic                         mode_strap_a_pin_out,
    output logic                         mode_strap_a_pin_oe,
    input  wire logic                    mode_strap_b_pin,
    // core side
    input  wire logic                    opcode_fetch,
    input  wire logic                    strobe_drive_high_bit,
    input  wire msp_pkg::msp_bus_t       bus,
    input  wire logic                    xa_enable,
    input  wire logic                    cs_enable,
    input  wire logic [`MSP_PG_XA_W-1:0] xa_lines,
    input  wire logic [`MSP_PH_CS_W-1:0] cs_lines,
    output msp_pkg::msp_mode_t           mode,
    output logic                         expanded_bus,
    output logic                         eclk,
    output logic [7:0]                   bus_data_in,
    // gpio side for the five bus ports
    input  wire logic [7:0]              gpio_b_out,
    input  wire logic [7:0]              gpio_b_oe,
    input  wire logic [7:0]              gpio_c_out,
    input  wire logic [7:0]              gpio_c_oe,
    input  wire logic [7:0]              gpio_f_out,
    input  wire logic [7:0]              gpio_f_oe,
    input  wire logic [7:0]              gpio_g_out,
    input  wire logic [7:0]              gpio_g_oe,
    input  wire logic [7:0]              gpio_h_out,
    input  wire logic [7:0]              gpio_h_oe,
    // pins of the muxed ports
    input  wire logic [7:0]              port_c_in,
    output logic [7:0]                   port_b_out,
    output logic [7:0]                   port_b_oe,
    output logic [7:0]                   port_c_out,
    output logic [7:0]                   port_c_oe,
    output logic [7:0]                   port_f_out,
    output logic [7:0]                   port_f_oe,
    output logic [7:0]                   port_g_out,
    output logic [7:0]                   port_g_oe,
    output logic [7:0]                   port_h_out,
    output logic [7:0]                   port_h_oe
);
    logic strap_a;
    logic strap_b;
    logic in_reset;
    logic cyc_start;
    logic fetch_cycle;
    logic strobe_en;
    logic xa_on;
    logic cs_on;

    initial begin
        // the high kick lasts one ref clock, a quarter only at this rate
        if (ECLK_DIV != `MSP_ECLK_DIV)
            $error("msp_pin_mux: ECLK_DIV must be 4");
    end

    // strap levels come from board pins, so they are synchronised
    msp_sync u_sync_a (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (mode_strap_a_pin_in),
        .level   (strap_a)
    );

    msp_sync u_sync_b (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (mode_strap_b_pin),
        .level   (strap_b)
    );

    msp_eclk #(
        .DIV (ECLK_DIV)
    ) u_eclk (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .eclk      (eclk),
        .cyc_start (cyc_start),
        .last_qtr  ()
    );

    // in_reset stays high until the first clocked cycle after release
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_reset <= 1'b1;
        end else begin
            in_reset <= 1'b0;
        end
    end

    // straps sampled on the first edge after release, frozen from then on
    // async reset cannot load a pin, so capture is clocked here
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode <= msp_pkg::MSP_SINGLE_CHIP;
        end else if (in_reset) begin
            mode <= msp_pkg::msp_mode_t'({strap_b, strap_a});
        end
    end // later strap changes are ignored

    // expanded and test modes both run the external bus
    assign expanded_bus = !in_reset && mode[0];
    assign strobe_en    = expanded_bus;
    // chip extras only in expanded modes and on the full variant
    assign xa_on = FULL_VARIANT && expanded_bus && xa_enable;
    assign cs_on = FULL_VARIANT && expanded_bus && cs_enable;

    // latch the fetch request at each e cycle start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetch_cycle <= 1'b0;
        end else if (cyc_start) begin
            fetch_cycle <= opcode_fetch;
        end
    end

    // open drain strobe: low during fetch, optional high kick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_strap_a_pin_out <= 1'b1;
            mode_strap_a_pin_oe  <= 1'b0;
        end else if (!strobe_en) begin
            mode_strap_a_pin_out <= 1'b1; // no function after reset
            mode_strap_a_pin_oe  <= 1'b0;
        end else if (cyc_start ? opcode_fetch : fetch_cycle) begin
            mode_strap_a_pin_out <= 1'b0;
            mode_strap_a_pin_oe  <= 1'b1;
        end else begin
            // drive high only in the quarter after a fetch cycle ends
            mode_strap_a_pin_out <= 1'b1;
            mode_strap_a_pin_oe  <= strobe_drive_high_bit &&
                                    fetch_cycle && cyc_start;
        end
    end

    // port b, f address and port c data, else gpio
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_b_out <= 8'h00;
            port_b_oe  <= 8'h00;
            port_f_out <= 8'h00;
            port_f_oe  <= 8'h00;
            port_c_out <= 8'h00;
            port_c_oe  <= 8'h00;
        end else if (expanded_bus) begin
            port_b_out <= bus.addr[15:8];
            port_b_oe  <= 8'hff;
            port_f_out <= bus.addr[7:0];
            port_f_oe  <= 8'hff;
            port_c_out <= bus.data_out;
            port_c_oe  <= {8{bus.data_oe}};
        end else begin
            port_b_out <= gpio_b_out;
            port_b_oe  <= gpio_b_oe;
            port_f_out <= gpio_f_out;
            port_f_oe  <= gpio_f_oe;
            port_c_out <= gpio_c_out;
            port_c_oe  <= gpio_c_oe;
        end
    end

    // read data sampled from port c pins, same clock as the core
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_data_in <= 8'h00;
        end else begin
            bus_data_in <= port_c_in;
        end
    end

    // port g: bit 7 read/write line, bits 6-0 expansion address
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_g_out <= 8'h00;
            port_g_oe  <= 8'h00;
        end else begin
            port_g_out[`MSP_PG_RW_BIT] <= expanded_bus ? bus.rw
                                        : gpio_g_out[`MSP_PG_RW_BIT];
            port_g_oe[`MSP_PG_RW_BIT]  <= expanded_bus ? 1'b1
                                        : gpio_g_oe[`MSP_PG_RW_BIT];
            port_g_out[6:0] <= xa_on ? xa_lines : gpio_g_out[6:0];
            // reduced variant has no port g low lines at all
            port_g_oe[6:0]  <= !FULL_VARIANT ? 7'h00
                             : xa_on ? 7'h7f : gpio_g_oe[6:0];
        end
    end

    // port h: upper nibble chip selects, lower nibble gpio
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_h_out <= 8'h00;
            port_h_oe  <= 8'h00;
        end else begin
            port_h_out[3:0] <= gpio_h_out[3:0];
            port_h_oe[3:0]  <= gpio_h_oe[3:0];
            port_h_out[7:4] <= cs_on ? cs_lines : gpio_h_out[7:4];
            port_h_oe[7:4]  <= !FULL_VARIANT ? 4'h0
                             : cs_on ? 4'hf : gpio_h_oe[7:4];
        end
    end
endmodule : msp_pin_mux

// ---- verilog/msp_pkg.sv ----
// types for the mode select pin mux
package msp_pkg;
    typedef enum logic [1:0] {
        MSP_SPECIAL_BOOT  = 2'b00,
        MSP_SPECIAL_TEST  = 2'b01,
        MSP_SINGLE_CHIP   = 2'b10,
        MSP_EXPANDED      = 2'b11
    } msp_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data_out;
        logic        data_oe;
        logic        rw;
    } msp_bus_t;
endpackage : msp_pkg

// ---- verilog/msp_sync.sv ----
// three stage synchroniser for one pin level with agreement filter
`timescale 1ns/100ps
`include "msp_consts.svh"
module msp_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // first stage feeds only the second; the stages keep running
    // through reset, because the straps must be seen while it is held,
    // so rst is left unread here on purpose
    always_ff @(posedge ref_clk) begin
        s1 <= pin;
        s2 <= s1;
        s3 <= s2;
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule : msp_sync
